// *** cnt_cfg_defines.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 125 MHz module clock, AHB-Lite word registers
// Notes: included by the counter configuration block
//
// Behaviour
// - several requests together raise load error, kept after all requests drop
// - status reset and load acceptance each take two bus cycles
// - program errors shown in feedback; load error held until acknowledged
// - parameter error clears only when a valid parameter set is accepted
// - continuous acknowledge or master stop makes load error follow its cause
// - channel diagnostic only when group diagnostics is enabled, default off
// - on master stop output one is off, running, substitute or held
// - filters on track A, B and aux input, 2.5 us or 25 us
// - pulse-direction or quadrature x1/x2/x4 decode, direction invertible
// - output one five functions, output two all but window switching
// - hysteresis 0..255 and pulse duration 0..255 in 2 ms units
// - aux input is plain, gate, latch-retrigger or sync; gate invertible
// - sync setting only matters when aux input is sync source
// - gate inversion without gate function is a parameter error
// - window switching with output two not plain is a parameter error
// - window switching with nonzero hysteresis is a parameter error
// - high limit outside 2..7FFFFFFF is a parameter error
// - undefined counting mode or main direction is a parameter error
// - acknowledging a comparator flag while its output is on re-sets it
// - sync-done flag set on sync, held until status reset
`ifndef CNT_CFG_DEFINES_SVH
`define CNT_CFG_DEFINES_SVH

`define OFS_PARAM0 8'h00
`define OFS_PARAM1 8'h04
`define OFS_LIMIT 8'h08
`define OFS_COMMIT 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_FEEDBACK 8'h14
`define OFS_ACT_PARAM0 8'h18
`define OFS_ACT_PARAM1 8'h1C
`define OFS_ACT_LIMIT 8'h20

`define P0_GROUP_DIAG 0
`define P0_STOP_LSB 1
`define P0_SUBST 3
`define P0_DIAG_OUT1 4
`define P0_EVAL_LSB 5
`define P0_FILT_A 7
`define P0_FILT_B 8
`define P0_FILT_AUX 9
`define P0_DIR_INV 10
`define P0_OUT1_LSB 11
`define P0_OUT2_LSB 14
`define P0_MODE_LSB 17
`define P0_GATE_FN 19
`define P0_GATE_INV 20
`define P0_AUX_LSB 21
`define P0_SYNC_PER 23
`define P0_DIR_LSB 24

`define P1_HYST_LSB 0
`define P1_PULSE_LSB 8

`define CT_REQ_LSB 0
`define CT_STS_RES 5
`define CT_CONT_ACK 6
`define CT_STOP 7
`define CT_SET_OUT1 8
`define CT_SET_OUT2 9

`define FB_LOAD_ERR 0
`define FB_PARAM_ERR 1
`define FB_SYNC_DONE 2
`define FB_CMP1 3
`define FB_CMP2 4
`define FB_RES_ACK 5
`define FB_LOAD_RUN 6

`define RST_PARAM0 32'h0000_0000
`define RST_PARAM1 32'h0000_0000
`define RST_LIMIT 32'h7FFF_FFFF
`define LIMIT_MIN 32'h0000_0002
`define LIMIT_MAX 32'h7FFF_FFFF

`define CLK_PERIOD_NS 8
`define FILT_SHORT_NS 2500
`define FILT_LONG_NS 25000
`define FILT_SHORT_CYC ((`FILT_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_LONG_CYC ((`FILT_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_UNIT_MS 2
`define PULSE_UNIT_CYC ((`PULSE_UNIT_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// *** cnt_cfg_pkg.sv ***
// Purpose: types of the counter configuration block
// Assumes: nothing
// Notes: encodings of the parameter fields
`default_nettype none
package cnt_cfg_pkg;
  typedef enum logic [1:0] {STOP_OFF = 2'h0, STOP_RUN = 2'h1, STOP_SUBST = 2'h2,
                            STOP_HOLD = 2'h3} stop_act_t;
  typedef enum logic [2:0] {DO_PLAIN = 3'h0, DO_GE = 3'h1, DO_LE = 3'h2, DO_PULSE = 3'h3,
                            DO_WINDOW = 3'h4} do_func_t;
  typedef enum logic [1:0] {AUX_PLAIN = 2'h0, AUX_GATE = 2'h1, AUX_LATCH = 2'h2,
                            AUX_SYNC = 2'h3} aux_func_t;
  typedef enum logic [1:0] {EVAL_PULSE_DIR = 2'h0, EVAL_X1 = 2'h1, EVAL_X2 = 2'h2,
                            EVAL_X4 = 2'h3} eval_t;
  typedef enum logic [1:0] {MODE_CONT = 2'h0, MODE_ONCE = 2'h1,
                            MODE_PERIODIC = 2'h2} cnt_mode_t;
  typedef enum logic [1:0] {DIR_NONE = 2'h0, DIR_UP = 2'h1, DIR_DOWN = 2'h2} main_dir_t;
  typedef enum logic [1:0] {HS_IDLE = 2'b01, HS_ACK = 2'b10} hs_state_t;
endpackage : cnt_cfg_pkg
`default_nettype wire

// *** counter_config_check_and_ack.sv ***
// Purpose: parameter check, request arbitration and acknowledge of a counter channel
// Assumes: one 125 MHz clock, AHB-Lite slave, bus_cycle_in marks each bus cycle
// Notes: counting datapath lies outside; it reads the active configuration
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`include "cnt_cfg_defines.svh"
`default_nettype none
module counter_config_check_and_ack #(
  parameter int unsigned PULSE_UNIT_CYC = `PULSE_UNIT_CYC
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic bus_cycle_in,
  input wire logic sync_event_in,
  input wire logic cmp_one_on_in,
  input wire logic cmp_two_on_in,
  output logic switch_output_one_out,
  output logic switch_output_two_out,
  output logic channel_diag_out,
  output logic [4:0] value_accept_out,
  output logic [11:0] filt_a_cycles_out,
  output logic [11:0] filt_b_cycles_out,
  output logic [11:0] filt_aux_cycles_out,
  output logic sync_periodic_out,
  output logic [31:0] pulse_cycles_out
);

  // ****************************************
  // bus slave
  // ****************************************
  logic [31:0] param0_r, param1_r, limit_r, act_p0_r, act_p1_r, act_limit_r;
  logic [9:0] control_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic commit_r;
  logic load_err_r, param_err_r, sync_done_r, cmp1_r, cmp2_r;
  cnt_cfg_pkg::hs_state_t res_hs_r, load_hs_r;
  logic [31:0] rd_nxt;
  logic acc;
  assign acc = hsel_in && hready_in && htrans_in[1];

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] fb);
    unique case (a)
      `OFS_PARAM0: rd_mux = param0_r;
      `OFS_PARAM1: rd_mux = param1_r;
      `OFS_LIMIT: rd_mux = limit_r;
      `OFS_CONTROL: rd_mux = {22'h0, control_r};
      `OFS_FEEDBACK: rd_mux = fb;
      `OFS_ACT_PARAM0: rd_mux = act_p0_r;
      `OFS_ACT_PARAM1: rd_mux = act_p1_r;
      `OFS_ACT_LIMIT: rd_mux = act_limit_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  always_comb begin
    rd_nxt = rd_mux(haddr_in[7:0], {25'h0, load_hs_r == cnt_cfg_pkg::HS_ACK,
             res_hs_r == cnt_cfg_pkg::HS_ACK, cmp2_r, cmp1_r, sync_done_r,
             param_err_r, load_err_r});
    if (haddr_in[31:8] != 24'h0) begin
      rd_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      wr_pend_r <= acc && hwrite_in && (haddr_in[31:8] == 24'h0);
      wr_addr_r <= haddr_in[7:0];
      if (acc && !hwrite_in) begin
        hrdata_out <= rd_nxt;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      param0_r <= `RST_PARAM0;
      param1_r <= `RST_PARAM1;
      limit_r <= `RST_LIMIT;
      control_r <= 10'h000;
      commit_r <= 1'b0;
    end else begin
      commit_r <= wr_pend_r && wr_addr_r == `OFS_COMMIT && hwdata_in[0];
      if (wr_pend_r) begin
        unique case (wr_addr_r)
          `OFS_PARAM0: param0_r <= hwdata_in;
          `OFS_PARAM1: param1_r <= {16'h0, hwdata_in[15:0]};
          `OFS_LIMIT: limit_r <= hwdata_in;
          `OFS_CONTROL: control_r <= hwdata_in[9:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // parameter check
  // ****************************************
  function automatic logic set_bad(input logic [31:0] p0, input logic [31:0] p1,
                                   input logic [31:0] lim);
    logic [2:0] f1, f2;
    logic bad;
    f1 = p0[`P0_OUT1_LSB +: 3];
    f2 = p0[`P0_OUT2_LSB +: 3];
    bad = 1'b0;
    if (p0[`P0_GATE_INV] && p0[`P0_AUX_LSB +: 2] != cnt_cfg_pkg::AUX_GATE) begin
      bad = 1'b1;
    end
    if (f1 == cnt_cfg_pkg::DO_WINDOW && f2 != cnt_cfg_pkg::DO_PLAIN) begin
      bad = 1'b1;
    end
    if (f1 == cnt_cfg_pkg::DO_WINDOW && p1[`P1_HYST_LSB +: 8] != 8'h00) begin
      bad = 1'b1;
    end
    if (lim < `LIMIT_MIN || lim > `LIMIT_MAX) begin
      bad = 1'b1;
    end
    if (p0[`P0_MODE_LSB +: 2] > cnt_cfg_pkg::MODE_PERIODIC ||
        p0[`P0_DIR_LSB +: 2] > cnt_cfg_pkg::DIR_DOWN) begin
      bad = 1'b1;
    end
    if (f1 > cnt_cfg_pkg::DO_WINDOW || f2 > cnt_cfg_pkg::DO_PULSE) begin
      bad = 1'b1;
    end
    if (p0[31:26] != 6'h00) begin
      bad = 1'b1;
    end
    set_bad = bad;
  endfunction : set_bad

  logic cur_bad;
  assign cur_bad = set_bad(param0_r, param1_r, limit_r);

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      act_p0_r <= `RST_PARAM0;
      act_p1_r <= `RST_PARAM1;
      act_limit_r <= `RST_LIMIT;
      param_err_r <= 1'b0;
    end else if (commit_r) begin
      param_err_r <= cur_bad;
      if (!cur_bad) begin
        act_p0_r <= param0_r;
        act_p1_r <= param1_r;
        act_limit_r <= limit_r;
      end
    end
  end

  // ****************************************
  // active configuration outputs
  // ****************************************
  function automatic logic [11:0] filt_cyc(input logic long_sel);
    filt_cyc = long_sel ? 12'(`FILT_LONG_CYC) : 12'(`FILT_SHORT_CYC);
  endfunction : filt_cyc

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      filt_a_cycles_out <= 12'(`FILT_SHORT_CYC);
      filt_b_cycles_out <= 12'(`FILT_SHORT_CYC);
      filt_aux_cycles_out <= 12'(`FILT_SHORT_CYC);
      sync_periodic_out <= 1'b0;
      pulse_cycles_out <= 32'h0000_0000;
    end else begin
      filt_a_cycles_out <= filt_cyc(act_p0_r[`P0_FILT_A]);
      filt_b_cycles_out <= filt_cyc(act_p0_r[`P0_FILT_B]);
      filt_aux_cycles_out <= filt_cyc(act_p0_r[`P0_FILT_AUX]);
      sync_periodic_out <= act_p0_r[`P0_AUX_LSB +: 2] == cnt_cfg_pkg::AUX_SYNC &&
                           act_p0_r[`P0_SYNC_PER];
      pulse_cycles_out <= 32'(act_p1_r[`P1_PULSE_LSB +: 8] * PULSE_UNIT_CYC);
    end
  end

  // ****************************************
  // request arbitration and handshakes
  // ****************************************
  logic [4:0] req;
  logic multi_req, res_req, stopped, follow;
  assign req = control_r[`CT_REQ_LSB +: 5];
  assign multi_req = (req & (req - 5'h01)) != 5'h00;
  assign res_req = control_r[`CT_STS_RES];
  assign stopped = control_r[`CT_STOP];
  assign follow = control_r[`CT_CONT_ACK] || stopped;
  logic res_rise;
  assign res_rise = bus_cycle_in && res_hs_r == cnt_cfg_pkg::HS_IDLE && res_req;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      res_hs_r <= cnt_cfg_pkg::HS_IDLE;
    end else if (bus_cycle_in) begin
      unique case (res_hs_r)
        cnt_cfg_pkg::HS_IDLE: if (res_req) res_hs_r <= cnt_cfg_pkg::HS_ACK;
        cnt_cfg_pkg::HS_ACK: if (!res_req) res_hs_r <= cnt_cfg_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      load_hs_r <= cnt_cfg_pkg::HS_IDLE;
      value_accept_out <= 5'h00;
    end else begin
      value_accept_out <= 5'h00;
      if (bus_cycle_in) begin
        unique case (load_hs_r)
          cnt_cfg_pkg::HS_IDLE: begin
            if (req != 5'h00 && !multi_req) begin
              load_hs_r <= cnt_cfg_pkg::HS_ACK;
              value_accept_out <= req;
            end
          end
          cnt_cfg_pkg::HS_ACK: if (req == 5'h00) load_hs_r <= cnt_cfg_pkg::HS_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // error and status flags
  // ****************************************
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      load_err_r <= 1'b0;
    end else if (multi_req) begin
      load_err_r <= 1'b1;
    end else if (req == 5'h00 && (follow || res_rise)) begin
      load_err_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync_done_r <= 1'b0;
      cmp1_r <= 1'b0;
      cmp2_r <= 1'b0;
    end else begin
      sync_done_r <= sync_event_in || (sync_done_r && !res_rise);
      cmp1_r <= cmp_one_on_in || (cmp1_r && !res_rise);
      cmp2_r <= cmp_two_on_in || (cmp2_r && !res_rise);
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      channel_diag_out <= 1'b0;
    end else begin
      channel_diag_out <= act_p0_r[`P0_GROUP_DIAG] && (load_err_r || param_err_r);
    end
  end

  // ****************************************
  // switching outputs
  // ****************************************
  logic out1_run, out2_run;
  assign out1_run = act_p0_r[`P0_OUT1_LSB +: 3] == cnt_cfg_pkg::DO_PLAIN ?
                    control_r[`CT_SET_OUT1] : cmp_one_on_in;
  assign out2_run = act_p0_r[`P0_OUT2_LSB +: 3] == cnt_cfg_pkg::DO_PLAIN ?
                    control_r[`CT_SET_OUT2] : cmp_two_on_in;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      switch_output_one_out <= 1'b0;
      switch_output_two_out <= 1'b0;
    end else begin
      switch_output_two_out <= out2_run;
      if (!stopped) begin
        switch_output_one_out <= out1_run;
      end else begin
        unique case (act_p0_r[`P0_STOP_LSB +: 2])
          cnt_cfg_pkg::STOP_OFF: switch_output_one_out <= 1'b0;
          cnt_cfg_pkg::STOP_RUN: switch_output_one_out <= out1_run;
          cnt_cfg_pkg::STOP_SUBST: switch_output_one_out <= act_p0_r[`P0_SUBST];
          cnt_cfg_pkg::STOP_HOLD: ;
        endcase
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_res_seen;
    bus_cycle_in && res_req && res_hs_r == cnt_cfg_pkg::HS_IDLE;
  endsequence
  sequence s_multi;
    multi_req;
  endsequence

  a_load_err_set: assert property (s_multi |=> load_err_r)
    else $error("load error not raised on multiple requests");
  a_load_err_hold: assert property (load_err_r && req != 5'h00 |=> load_err_r)
    else $error("load error dropped while requests remain");
  a_res_ack: assert property (s_res_seen |=> res_hs_r == cnt_cfg_pkg::HS_ACK)
    else $error("status reset not acknowledged");
  a_sync_clear: assert property (s_res_seen ##0 !sync_event_in |=> !sync_done_r)
    else $error("sync flag not cleared by status reset");
  a_cmp_reset: assert property (cmp_one_on_in |=> cmp1_r)
    else $error("comparator flag not re-set while output on");
  a_param_keep: assert property (commit_r && cur_bad |=> $stable(act_p0_r) && param_err_r)
    else $error("bad parameter set took effect");
  a_param_clear: assert property (param_err_r && !commit_r |=> param_err_r)
    else $error("parameter error cleared without valid set");
  a_diag_gate: assert property (!act_p0_r[`P0_GROUP_DIAG] |=> !channel_diag_out)
    else $error("diagnostic without group diagnostics");
  a_stop_off: assert property (stopped && act_p0_r[`P0_STOP_LSB +: 2] == 2'h0
                               |=> !switch_output_one_out)
    else $error("output one on during stop");
  a_follow_err: assert property (follow && req == 5'h00 |=> !load_err_r)
    else $error("load error held under continuous acknowledge");
  a_multi_none: assert property (s_multi |=> value_accept_out == 5'h00)
    else $error("value accepted despite multiple requests");
  a_accept_onehot: assert property (value_accept_out != 5'h00
                                    |-> $onehot(value_accept_out))
    else $error("more than one value accepted");
  a_res_release: assert property (bus_cycle_in && !res_req &&
                                  res_hs_r == cnt_cfg_pkg::HS_ACK |=> res_hs_r == cnt_cfg_pkg::HS_IDLE)
    else $error("status reset acknowledge not released");
  a_diag_show: assert property (act_p0_r[`P0_GROUP_DIAG] &&
                                (load_err_r || param_err_r) |=> channel_diag_out)
    else $error("diagnostic missing with group diagnostics enabled");
  a_cmp_hold: assert property (cmp1_r && !res_rise |=> cmp1_r)
    else $error("comparator flag dropped without acknowledge");
  a_valid_accept: assert property (commit_r && !cur_bad
                                   |=> !param_err_r && act_limit_r == $past(limit_r))
    else $error("valid parameter set not taken");

endmodule : counter_config_check_and_ack
`default_nettype wire

// *** iso_cycle_source.sv ***
// Purpose: controller side bus cycle source for the counter block bench
// Assumes: one clock shared with the block, reset active high
// Notes: one-clock pulse every PERIOD clocks, silent during reset
`default_nettype none
module iso_cycle_source #(
  parameter int PERIOD = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  output logic bus_cycle_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  // ****************
  // bus cycle pulse
  // ****************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_r <= 8'h00;
      bus_cycle_out <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
      bus_cycle_out <= (cnt_r == 8'(PERIOD - 1));
    end
  end
endmodule : iso_cycle_source
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench of the counter configuration block
// Assumes: 125 MHz clock, zero-wait bus slave, one bus cycle per 16 clocks
// Notes: pulse unit shortened to 4 clocks
`include "cnt_cfg_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VALID = 32'h02EC_26E0;
  logic clk, rst, hsel, hwrite, hready, hresp, sync_ev, cmp1, cmp2, bus_cyc;
  logic out1, out2, diag, sync_per;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, pulse_cyc, p;
  logic [4:0] accept, acc_last;
  logic [11:0] fa, fb, fx;
  logic [31:0] bad_p0 [7] = '{32'h0010_0000, 32'h0000_6000, 32'h0000_2000, 32'h0, 32'h0,
                              32'h0006_0000, 32'h0300_0000};
  logic [31:0] bad_p1 [7] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] bad_lim [7] = '{32'h64, 32'h64, 32'h64, 32'h1, 32'h8000_0000, 32'h64, 32'h64};
  logic [3:0] stop_exp [2] = '{4'b1100, 4'b1010};
  int mismatches, check_count, acc_cnt, acc_base;
  counter_config_check_and_ack #(.PULSE_UNIT_CYC(4)) DUT (
    .ref_clk_in(clk), .reset_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .bus_cycle_in(bus_cyc),
    .sync_event_in(sync_ev), .cmp_one_on_in(cmp1), .cmp_two_on_in(cmp2),
    .switch_output_one_out(out1), .switch_output_two_out(out2), .channel_diag_out(diag),
    .value_accept_out(accept), .filt_a_cycles_out(fa), .filt_b_cycles_out(fb),
    .filt_aux_cycles_out(fx), .sync_periodic_out(sync_per), .pulse_cycles_out(pulse_cyc));
  iso_cycle_source #(.PERIOD(16)) partner (.clk_in(clk), .reset_in(rst), .bus_cycle_out(bus_cyc));
  // ****************
  // clock and monitors
  // ****************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (accept !== 5'h00) begin
      acc_cnt++;
      acc_last <= accept;
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic timeout(input string what);
    mismatches++;
    $display("unexpected %s: expected response seen none", what);
    conclude();
  endtask : timeout
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) timeout("hready");
  endtask : wait_ready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    check(name, d, e);
  endtask : rchk
  task automatic fbchk(input string name, input int b, input logic e);
    logic [31:0] d;
    xfer(1'b0, `OFS_FEEDBACK, 32'h0, d);
    check(name, d[b], e);
  endtask : fbchk
  task automatic wait_cycle();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bus_cyc !== 1'b1 && n < 40);
    if (bus_cyc !== 1'b1) timeout("bus cycle");
    repeat (3) @(posedge clk);
  endtask : wait_cycle
  task automatic commit(input logic [31:0] p0, input logic [31:0] p1, input logic [31:0] lim);
    wr(`OFS_PARAM0, p0);
    wr(`OFS_PARAM1, p1);
    wr(`OFS_LIMIT, lim);
    wr(`OFS_COMMIT, 32'h1);
    repeat (3) @(posedge clk);
  endtask : commit
  // one request over three bus cycles: set, see ack, clear, see ack drop
  task automatic hs(input logic [31:0] ctl, input int ab, input logic [4:0] acc);
    int n;
    wait_cycle();
    n = acc_cnt;
    wr(`OFS_CONTROL, ctl);
    fbchk("ack_early", ab, 1'b0);
    wait_cycle();
    fbchk("ack", ab, 1'b1);
    check("accept_count", acc_cnt - n, (acc != 5'h00));
    if (acc != 5'h00) check("accept_bit", acc_last, acc);
    wr(`OFS_CONTROL, 32'h0);
    fbchk("ack_held", ab, 1'b1);
    wait_cycle();
    fbchk("ack_drop", ab, 1'b0);
  endtask : hs
  // ****************
  // main sequence
  // ****************
  initial begin
    rst = 1'b1;
    {hsel, hwrite, sync_ev, cmp1, cmp2} = 5'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    acc_last = 5'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check("filt_a", fa, `FILT_SHORT_CYC);
    check("hresp", hresp, 1'b0);
    rchk("param0", `OFS_PARAM0, `RST_PARAM0);
    rchk("param1", `OFS_PARAM1, `RST_PARAM1);
    rchk("act_limit", `OFS_ACT_LIMIT, `RST_LIMIT);
    rchk("feedback", `OFS_FEEDBACK, 32'h0);
    wr(32'h100, 32'hFFFF_FFFF);
    rchk("unmapped", 32'h100, 32'h0);
    $display("test defaults done");
    commit(VALID, 32'h0000_0700, `LIMIT_MIN);
    rchk("act_param0", `OFS_ACT_PARAM0, VALID);
    rchk("act_limit", `OFS_ACT_LIMIT, `LIMIT_MIN);
    fbchk("param_err", `FB_PARAM_ERR, 1'b0);
    check("filt_a", fa, `FILT_LONG_CYC);
    check("filt_b", fb, `FILT_SHORT_CYC);
    check("filt_aux", fx, `FILT_LONG_CYC);
    check("sync_per", sync_per, 1'b1);
    check("pulse", pulse_cyc, 32'h1C);
    wr(`OFS_ACT_PARAM0, 32'h0);
    rchk("act_param0", `OFS_ACT_PARAM0, VALID);
    for (int i = 0; i < 7; i++) begin
      commit(bad_p0[i], bad_p1[i], bad_lim[i]);
      fbchk("param_err", `FB_PARAM_ERR, 1'b1);
      rchk("act_param0", `OFS_ACT_PARAM0, VALID);
      check("diag", diag, 1'b0);
    end
    hs(32'h20, `FB_RES_ACK, 5'h00);
    fbchk("param_err", `FB_PARAM_ERR, 1'b1);
    commit(32'h0080_0001, 32'h0, `RST_LIMIT);
    fbchk("param_err", `FB_PARAM_ERR, 1'b0);
    check("sync_per", sync_per, 1'b0);
    $display("test parameters done");
    wait_cycle();
    acc_base = acc_cnt;
    wr(`OFS_CONTROL, 32'h7);
    wait_cycle();
    fbchk("load_err", `FB_LOAD_ERR, 1'b1);
    check("diag", diag, 1'b1);
    check("accepts", acc_cnt - acc_base, 32'h0);
    wr(`OFS_CONTROL, 32'h3);
    wait_cycle();
    fbchk("load_err", `FB_LOAD_ERR, 1'b1);
    wr(`OFS_CONTROL, 32'h0);
    wait_cycle();
    fbchk("load_err", `FB_LOAD_ERR, 1'b1);
    hs(32'h20, `FB_RES_ACK, 5'h00);
    fbchk("load_err", `FB_LOAD_ERR, 1'b0);
    check("diag", diag, 1'b0);
    wr(`OFS_CONTROL, 32'h43);
    wait_cycle();
    fbchk("load_err", `FB_LOAD_ERR, 1'b1);
    wr(`OFS_CONTROL, 32'h40);
    wait_cycle();
    fbchk("load_err", `FB_LOAD_ERR, 1'b0);
    wr(`OFS_CONTROL, 32'h0);
    for (int i = 0; i < 5; i++) hs(32'h1 << i, `FB_LOAD_RUN, 5'h01 << i);
    $display("test requests done");
    sync_ev <= 1'b1;
    cmp1 <= 1'b1;
    cmp2 <= 1'b1;
    @(posedge clk);
    sync_ev <= 1'b0;
    cmp2 <= 1'b0;
    wait_cycle();
    wait_cycle();
    fbchk("sync_done", `FB_SYNC_DONE, 1'b1);
    fbchk("cmp2_flag", `FB_CMP2, 1'b1);
    hs(32'h20, `FB_RES_ACK, 5'h00);
    fbchk("cmp1_flag", `FB_CMP1, 1'b1);
    fbchk("cmp2_flag", `FB_CMP2, 1'b0);
    fbchk("sync_done", `FB_SYNC_DONE, 1'b0);
    cmp1 <= 1'b0;
    hs(32'h20, `FB_RES_ACK, 5'h00);
    fbchk("cmp1_flag", `FB_CMP1, 1'b0);
    $display("test flags done");
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a < 4; a++) begin
        p = 32'(a) << 1;
        p[3] = (s == 0);
        commit(p, 32'h0, `RST_LIMIT);
        wr(`OFS_CONTROL, 32'h100);
        repeat (3) @(posedge clk);
        check("out1_run", out1, 1'b1);
        wr(`OFS_CONTROL, (s == 0) ? 32'h80 : 32'h180);
        repeat (3) @(posedge clk);
        check("out1_stop", out1, stop_exp[s][a]);
      end
    end
    wr(`OFS_CONTROL, 32'h200);
    repeat (3) @(posedge clk);
    check("out2", out2, 1'b1);
    commit(32'h0000_4800, 32'h0, `RST_LIMIT);
    wr(`OFS_CONTROL, 32'h0);
    cmp1 <= 1'b1;
    repeat (3) @(posedge clk);
    check("out1_cmp", out1, 1'b1);
    check("out2_cmp", out2, 1'b0);
    cmp1 <= 1'b0;
    $display("test outputs done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
